// ==== logic/lsf_top.sv ====
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// (RL1) Sink A function bit 15 picks steady LED driving at 0 and timed flashing at 1.
// (RL2) In flash mode bit 14 picks the trigger: 0 the drive bit, 1 the flash pin.
// (RL3) The trigger source bit has no effect while sink A is in LED mode.
// (RL4) In LED mode drive bit 13 turns sink A on at 1 and off at 0.
// (RL5) With the register trigger, a rising drive bit starts one flash.
// (RL6) After a register-triggered flash the drive bit is cleared when the duration ends.
// (RL7) With the pin trigger, the drive bit neither starts nor affects a flash.
// (RL8) Repeat bit 12 gives one flash per trigger at 0 and a flash every 4 s at 1.
// (RL9) Length field 9:8 gives 32, 64, 96 or 1024 ms per flash.
// (RL10) Field 5:4 sets ramp-down: instant/0.25/0.5/1 s in LED mode, instant/1.95/3.91/7.8 ms flash.
// (RL11) Field 1:0 sets ramp-up with the same mode-dependent coding as ramp-down.
// (RL12) Drive defaults to zero and the power state machine clears every sink field.
// (RL13) Sink B enable bit 15 turns the second sink off at 0 and on at 1.
// (RL14) Sink B bit 12 at 0 forces it off in hibernate, at 1 keeps its active state.
// (RL15) Sink A enable bit 15 in its own register gates sink A, and is cleared by the power machine.
// (RL16) Sink B level code 5:0, reset to zero, is passed unchanged to the analogue sink.
module lsf_top import lsf_pkg::*; #(
  parameter int unsigned FLASH_UNIT_CYCLES = FLASH_UNIT_CYC,
  parameter int unsigned REPEAT_CYCLES = REPEAT_CYC,
  parameter int unsigned LED_STEP_CYCLES = LED_STEP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic flash_pin_i,
  input wire logic hibernate_i,
  input wire logic psm_clear_i,
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [7:0] sink_a_level_o,
  output logic sink_a_pin_o,
  output logic sink_b_pin_o,
  output logic [5:0] sink_b_level_code_o
);
  typedef struct packed {
    logic a_ena;
    lsf_a_ctl_s a_ctl;
    lsf_b_ctl_s b_ctl;
    lsf_flash_e fsm;
    logic drive_prev;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic aw_hold;
    logic [15:0] awaddr;
    logic w_hold;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [7:0] a_level;
    logic a_on;
    logic b_on;
    logic [5:0] b_code;
  } lsf_top_s;

  lsf_top_s st_reg;
  lsf_top_s st_next;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic dur_busy, dur_done, rep_busy, rep_done;
  logic fl_start, fl_end, rep_run;
  logic drive_edge, pin_edge, trig;
  logic ramp_target;
  logic [31:0] ramp_base, ramp_step, dur_val;
  logic [7:0] ramp_level;
  logic wr_go, wr_drive_set;
  logic [15:0] wmask, old16, new16, rd16;
  logic [1:0] code;

  function automatic logic [15:0] a_pack(lsf_a_ctl_s c);
    logic [15:0] r;
    r = '0;
    r[FUNC_BIT] = c.sink_a_function_select;
    r[SRC_BIT] = c.sink_a_trigger_source;
    r[DRIVE_BIT] = c.sink_a_drive_trigger;
    r[REPEAT_BIT] = c.sink_a_repeat_select;
    r[LEN_LSB +: 2] = c.sink_a_pulse_length;
    r[OFF_LSB +: 2] = c.sink_a_rampdown_time;
    r[ON_LSB +: 2] = c.sink_a_rampup_time;
    return r;
  endfunction

  function automatic logic [15:0] b_pack(lsf_b_ctl_s c);
    logic [15:0] r;
    r = '0;
    r[B_ENA_BIT] = c.sink_b_output_on;
    r[B_SLEEP_BIT] = c.sink_b_sleep_behaviour;
    r[B_LEVEL_LSB +: 6] = c.sink_b_level_code;
    return r;
  endfunction

  always_comb begin
    // Input edges and flash triggers
    drive_edge = st_reg.a_ctl.sink_a_drive_trigger && !st_reg.drive_prev;
    pin_edge = st_reg.pin_s2 && !st_reg.pin_prev;
    rep_run = st_reg.a_ctl.sink_a_function_select && st_reg.a_ctl.sink_a_repeat_select; // RL8
    trig = (st_reg.a_ctl.sink_a_trigger_source ? pin_edge : drive_edge) // RL2 RL7
      || (rep_run && rep_done); // RL8
    fl_start = st_reg.fsm == FL_IDLE && st_reg.a_ctl.sink_a_function_select && trig; // RL3 RL5
    fl_end = st_reg.fsm == FL_RUN && dur_done;
    case (st_reg.a_ctl.sink_a_pulse_length) // RL9
      2'h0: dur_val = 32'(FLASH_UNIT_CYCLES);
      2'h1: dur_val = 32'(2 * FLASH_UNIT_CYCLES);
      2'h2: dur_val = 32'(3 * FLASH_UNIT_CYCLES);
      default: dur_val = 32'(LEN_LONG_UNITS * FLASH_UNIT_CYCLES);
    endcase
    // Ramp target and step period
    ramp_target = st_reg.a_ctl.sink_a_function_select ? (st_reg.fsm == FL_RUN) // RL1
      : st_reg.a_ctl.sink_a_drive_trigger; // RL4
    ramp_base = st_reg.a_ctl.sink_a_function_select ? FLASH_STEP_CYC : 32'(LED_STEP_CYCLES);
    code = ramp_target ? st_reg.a_ctl.sink_a_rampup_time // RL11
      : st_reg.a_ctl.sink_a_rampdown_time; // RL10
    case (code)
      2'h0: ramp_step = '0;
      2'h1: ramp_step = ramp_base;
      2'h2: ramp_step = ramp_base << 1;
      default: ramp_step = ramp_base << 2;
    endcase
    // Register write path
    wr_go = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
    wmask = {{8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    case (st_reg.awaddr[15:2])
      ADDR_A_ENABLE[15:2]: old16 = {st_reg.a_ena, 15'h0};
      ADDR_A_FLASH[15:2]: old16 = a_pack(st_reg.a_ctl);
      ADDR_B_DRIVE[15:2]: old16 = b_pack(st_reg.b_ctl);
      default: old16 = '0;
    endcase
    new16 = (old16 & ~wmask) | (st_reg.wdata & wmask);
    wr_drive_set = wr_go && st_reg.awaddr[15:2] == ADDR_A_FLASH[15:2] && new16[DRIVE_BIT];
    case (s_axi_araddr_i[15:2])
      ADDR_A_ENABLE[15:2]: rd16 = {st_reg.a_ena, 15'h0};
      ADDR_A_FLASH[15:2]: rd16 = a_pack(st_reg.a_ctl);
      ADDR_B_DRIVE[15:2]: rd16 = b_pack(st_reg.b_ctl);
      default: rd16 = '0;
    endcase

    st_next = st_reg;
    st_next.pin_s1 = flash_pin_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_prev = st_reg.pin_s2;
    st_next.drive_prev = st_reg.a_ctl.sink_a_drive_trigger;

    // Flash sequencer
    case (st_reg.fsm)
      FL_IDLE: begin
        if (fl_start) begin
          st_next.fsm = FL_RUN; // RL5
        end
      end
      FL_RUN: begin
        if (!st_reg.a_ctl.sink_a_function_select) begin
          st_next.fsm = FL_IDLE; // RL1
        end else if (dur_done) begin
          st_next.fsm = FL_IDLE;
          if (!st_reg.a_ctl.sink_a_trigger_source) begin
            st_next.a_ctl.sink_a_drive_trigger = 1'b0; // RL6
          end
        end
      end
      default: st_next.fsm = FL_IDLE;
    endcase

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid_i && st_reg.awready) begin
      st_next.aw_hold = 1'b1;
      st_next.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_reg.wready) begin
      st_next.w_hold = 1'b1;
      st_next.wdata = s_axi_wdata_i[15:0];
      st_next.wstrb = s_axi_wstrb_i[1:0];
    end
    if (wr_go) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.awaddr[15:2])
        ADDR_A_ENABLE[15:2]: st_next.a_ena = new16[A_ENA_BIT]; // RL15
        ADDR_A_FLASH[15:2]: begin
          st_next.a_ctl.sink_a_function_select = new16[FUNC_BIT];
          st_next.a_ctl.sink_a_trigger_source = new16[SRC_BIT];
          // A written drive bit wins over the end-of-flash clear; an unwritten lane keeps it
          st_next.a_ctl.sink_a_drive_trigger = st_reg.wstrb[1] ? new16[DRIVE_BIT]
            : st_next.a_ctl.sink_a_drive_trigger;
          st_next.a_ctl.sink_a_repeat_select = new16[REPEAT_BIT];
          st_next.a_ctl.sink_a_pulse_length = new16[LEN_LSB +: 2];
          st_next.a_ctl.sink_a_rampdown_time = new16[OFF_LSB +: 2];
          st_next.a_ctl.sink_a_rampup_time = new16[ON_LSB +: 2];
        end
        ADDR_B_DRIVE[15:2]: begin
          st_next.b_ctl.sink_b_output_on = new16[B_ENA_BIT];
          st_next.b_ctl.sink_b_sleep_behaviour = new16[B_SLEEP_BIT];
          st_next.b_ctl.sink_b_level_code = new16[B_LEVEL_LSB +: 6];
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end

    // Read channel
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd16;
      case (s_axi_araddr_i[15:2])
        ADDR_A_ENABLE[15:2], ADDR_A_FLASH[15:2], ADDR_B_DRIVE[15:2]: st_next.rresp = RESP_OKAY;
        default: st_next.rresp = RESP_SLVERR;
      endcase
    end

    // Power state machine returns every field to its default
    if (psm_clear_i) begin
      st_next.a_ena = 1'b0; // RL12 RL15
      st_next.a_ctl = A_CTL_RST; // RL12
      st_next.b_ctl = B_CTL_RST; // RL12
      st_next.fsm = FL_IDLE;
    end

    st_next.awready = !st_next.aw_hold && !st_next.bvalid;
    st_next.wready = !st_next.w_hold && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;

    // Sink outputs
    st_next.a_level = st_reg.a_ena ? ramp_level : 8'h00; // RL15
    st_next.a_on = st_reg.a_ena && ramp_level != 8'h00; // RL15
    st_next.b_on = st_reg.b_ctl.sink_b_output_on // RL13
      && (!hibernate_i || st_reg.b_ctl.sink_b_sleep_behaviour); // RL14
    st_next.b_code = st_reg.b_ctl.sink_b_level_code; // RL16
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{fsm: FL_IDLE, a_ctl: A_CTL_RST, b_ctl: B_CTL_RST, default: '0};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  lsf_countdown #(.W(32)) u_dur (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(fl_start),
    .clr_i(!st_reg.a_ctl.sink_a_function_select),
    .load_val_i(dur_val),
    .busy_o(dur_busy),
    .done_o(dur_done)
  );

  lsf_countdown #(.W(32)) u_rep (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(rep_run && !rep_busy),
    .clr_i(!rep_run),
    .load_val_i(32'(REPEAT_CYCLES)),
    .busy_o(rep_busy),
    .done_o(rep_done)
  );

  lsf_ramp u_ramp (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .target_i(ramp_target),
    .step_cyc_i(ramp_step),
    .level_o(ramp_level)
  );

  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o = st_reg.wready;
  assign s_axi_bresp_o = st_reg.bresp;
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rdata_o = {16'h0, st_reg.rdata};
  assign s_axi_rresp_o = st_reg.rresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign sink_a_level_o = st_reg.a_level;
  assign sink_a_pin_o = st_reg.a_on;
  assign sink_b_pin_o = st_reg.b_on;
  assign sink_b_level_code_o = st_reg.b_code;

  led_follow_a: assert property (!st_reg.a_ctl.sink_a_function_select |-> // RL4
    ramp_target == st_reg.a_ctl.sink_a_drive_trigger && ramp_base == 32'(LED_STEP_CYCLES))
    else $error("LED mode target does not follow the drive bit");
  led_no_flash_a: assert property (ce_i && !st_reg.a_ctl.sink_a_function_select |=> // RL3
    st_reg.fsm == FL_IDLE) else $error("flash sequencer active in LED mode");
  reg_start_a: assert property (ce_i && !psm_clear_i && st_reg.fsm == FL_IDLE // RL5
    && st_reg.a_ctl.sink_a_function_select && !st_reg.a_ctl.sink_a_trigger_source
    && drive_edge |=> st_reg.fsm == FL_RUN && dur_busy)
    else $error("rising drive bit did not start a flash");
  pin_ignore_a: assert property (ce_i && st_reg.fsm == FL_IDLE // RL7
    && st_reg.a_ctl.sink_a_trigger_source && !pin_edge && !rep_done |=> st_reg.fsm == FL_IDLE)
    else $error("flash started without a pin edge");
  drive_clear_a: assert property (ce_i && !psm_clear_i && fl_end // RL6
    && st_reg.a_ctl.sink_a_function_select && !st_reg.a_ctl.sink_a_trigger_source
    && !wr_drive_set |=> !st_reg.a_ctl.sink_a_drive_trigger && st_reg.fsm == FL_IDLE)
    else $error("drive bit not cleared at end of flash");
  repeat_fire_a: assert property (ce_i && !psm_clear_i && st_reg.fsm == FL_IDLE // RL8
    && rep_run && rep_done |=> st_reg.fsm == FL_RUN)
    else $error("periodic retrigger did not start a flash");
  psm_clear_a: assert property (ce_i && psm_clear_i |=> // RL12
    st_reg.a_ctl == A_CTL_RST && st_reg.b_ctl == B_CTL_RST && !st_reg.a_ena)
    else $error("power state machine clear left a field set");
  a_gate_a: assert property (ce_i && !st_reg.a_ena |=> sink_a_level_o == 8'h00 // RL15
    && !sink_a_pin_o) else $error("sink A driven while disabled");
  b_off_a: assert property (ce_i && !st_reg.b_ctl.sink_b_output_on |=> !sink_b_pin_o) // RL13
    else $error("sink B on while disabled");
  b_hib_a: assert property (ce_i && hibernate_i // RL14
    && !st_reg.b_ctl.sink_b_sleep_behaviour |=> !sink_b_pin_o)
    else $error("sink B on in hibernate");
  b_code_a: assert property (ce_i ##1 ce_i |-> // RL16
    sink_b_level_code_o == $past(st_reg.b_ctl.sink_b_level_code))
    else $error("sink B level code not forwarded");
  pulse_len_a: assert property (fl_start && st_reg.a_ctl.sink_a_pulse_length == 2'h3 |-> // RL9
    dur_val == 32'(32 * FLASH_UNIT_CYCLES)) else $error("long flash length wrong");

endmodule // lsf_top

// ==== logic/lsf_pkg.sv ====
package lsf_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Register indices and byte addresses (byte address is four times the index)
  localparam logic [11:0] IDX_A_ENABLE = 12'h0ac;
  localparam logic [11:0] IDX_A_FLASH = 12'h0ad;
  localparam logic [11:0] IDX_B_DRIVE = 12'h0ae;
  localparam logic [15:0] ADDR_A_ENABLE = {2'h0, IDX_A_ENABLE, 2'h0};
  localparam logic [15:0] ADDR_A_FLASH = {2'h0, IDX_A_FLASH, 2'h0};
  localparam logic [15:0] ADDR_B_DRIVE = {2'h0, IDX_B_DRIVE, 2'h0};

  // Field positions
  localparam int A_ENA_BIT = 15;
  localparam int FUNC_BIT = 15;
  localparam int SRC_BIT = 14;
  localparam int DRIVE_BIT = 13;
  localparam int REPEAT_BIT = 12;
  localparam int LEN_LSB = 8;
  localparam int OFF_LSB = 4;
  localparam int ON_LSB = 0;
  localparam int B_ENA_BIT = 15;
  localparam int B_SLEEP_BIT = 12;
  localparam int B_LEVEL_LSB = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing, in the printed units, and derived cycle counts
  localparam int FLASH_UNIT_MS = 32;
  localparam int LEN_LONG_UNITS = 1024 / FLASH_UNIT_MS;
  localparam int REPEAT_S = 4;
  localparam int LED_RAMP_BASE_NS = 250_000_000;
  localparam int FLASH_RAMP_BASE_NS = 1_950_000;
  localparam int RAMP_STEPS = 256;
  localparam int FLASH_UNIT_CYC = FLASH_UNIT_MS * (1_000_000 / CLK_PERIOD_NS);
  localparam int REPEAT_CYC = REPEAT_S * (1_000_000_000 / CLK_PERIOD_NS);
  localparam int LED_STEP_CYC = LED_RAMP_BASE_NS / CLK_PERIOD_NS / RAMP_STEPS;
  localparam logic [31:0] FLASH_STEP_CYC = 32'(FLASH_RAMP_BASE_NS / CLK_PERIOD_NS / RAMP_STEPS);

  typedef struct packed {
    logic sink_a_function_select;
    logic sink_a_trigger_source;
    logic sink_a_drive_trigger;
    logic sink_a_repeat_select;
    logic [1:0] sink_a_pulse_length;
    logic [1:0] sink_a_rampdown_time;
    logic [1:0] sink_a_rampup_time;
  } lsf_a_ctl_s;

  typedef struct packed {
    logic sink_b_output_on;
    logic sink_b_sleep_behaviour;
    logic [5:0] sink_b_level_code;
  } lsf_b_ctl_s;

  localparam lsf_a_ctl_s A_CTL_RST = '0;
  localparam lsf_b_ctl_s B_CTL_RST = '0;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b01,
    FL_RUN = 2'b10
  } lsf_flash_e;

endpackage

// ==== logic/lsf_countdown.sv ====
`timescale 1ns/10ps
module lsf_countdown #(
  parameter int W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic clr_i,
  input wire logic [W-1:0] load_val_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } lsf_cd_s;

  lsf_cd_s st_reg;
  lsf_cd_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (clr_i) begin
      st_next.cnt = '0;
    end else if (load_i) begin
      st_next.cnt = load_val_i;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
      st_next.done = (st_reg.cnt == W'(1));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign busy_o = (st_reg.cnt != '0);
  assign done_o = st_reg.done;

  done_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && !clr_i && !load_i && st_reg.cnt == W'(1) |=> done_o && !busy_o)
    else $error("countdown did not finish on its last count");

endmodule // lsf_countdown

// ==== logic/lsf_ramp.sv ====
`timescale 1ns/10ps
module lsf_ramp (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic target_i,
  input wire logic [31:0] step_cyc_i,
  output logic [7:0] level_o
);
  typedef struct packed {
    logic [7:0] level;
    logic [31:0] pre;
  } lsf_ramp_s;

  lsf_ramp_s st_reg;
  lsf_ramp_s st_next;
  logic [7:0] goal;

  always_comb begin
    st_next = st_reg;
    goal = target_i ? 8'hff : 8'h00;
    if (st_reg.level == goal) begin
      st_next.pre = '0;
    end else if (step_cyc_i == '0) begin
      st_next.level = goal;
      st_next.pre = '0;
    end else if (st_reg.pre + 32'h1 >= step_cyc_i) begin
      st_next.pre = '0;
      st_next.level = target_i ? st_reg.level + 8'h1 : st_reg.level - 8'h1;
    end else begin
      st_next.pre = st_reg.pre + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

  instant_on_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RL11
    ce_i && target_i && step_cyc_i == '0 |=> level_o == 8'hff)
    else $error("instant switch-on did not reach full level");

  instant_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RL10
    ce_i && !target_i && step_cyc_i == '0 |=> level_o == 8'h00)
    else $error("instant switch-off did not reach zero");

endmodule // lsf_ramp

// ==== tb/lsf_led_load.sv ====
`timescale 1ns/10ps
module lsf_led_load (
  input wire logic ref_clk_i,
  input wire logic sink_a_pin_i,
  output int flash_cnt_o,
  output int last_on_o
);
  int run;
  logic was_on;
  // Counts lit periods of the sink A string and times the latest one
  always @(posedge ref_clk_i) begin
    was_on <= sink_a_pin_i;
    if (sink_a_pin_i === 1'b1 && was_on !== 1'b1) begin
      flash_cnt_o <= flash_cnt_o + 1;
      run <= 1;
    end else if (sink_a_pin_i === 1'b1) begin
      run <= run + 1;
    end else if (was_on === 1'b1) begin
      last_on_o <= run;
    end
  end
endmodule // lsf_led_load

// ==== tb/led_sink_flash_control_tb.sv ====
`timescale 1ns/10ps
module led_sink_flash_control_tb import lsf_pkg::*;;
  localparam int U = 20;
  logic clk, rst_n, pin, hib, psm, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, a_on, b_on;
  logic [1:0] bresp, rresp;
  logic [7:0] a_lvl;
  logic [5:0] b_code;
  int flashes, on_len, error_cnt, samples_checked, cyc, n0, u;

  lsf_top #(.FLASH_UNIT_CYCLES(U), .REPEAT_CYCLES(200), .LED_STEP_CYCLES(2)) DUT (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .flash_pin_i(pin), .hibernate_i(hib),
    .psm_clear_i(psm), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sink_a_level_o(a_lvl),
    .sink_a_pin_o(a_on), .sink_b_pin_o(b_on), .sink_b_level_code_o(b_code));

  lsf_led_load LOAD (.ref_clk_i(clk), .sink_a_pin_i(a_on), .flash_cnt_o(flashes),
    .last_on_o(on_len));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, {16'h0, exp});
    chk("rresp", rresp, er);
  endtask

  initial begin
    {rst_n, pin, hib, psm, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    error_cnt = 0;
    samples_checked = 0;
    wt(5);
    rst_n <= 1'b1;
    rd(ADDR_A_ENABLE, 16'h0, RESP_OKAY);
    rd(ADDR_A_FLASH, 16'h0, RESP_OKAY);
    rd(ADDR_B_DRIVE, 16'h0, RESP_OKAY);
    wr(16'h02bc, 16'hffff, 4'hf, RESP_SLVERR);
    rd(16'h02bc, 16'h0, RESP_SLVERR);
    // Sink B enable, sleep behaviour and level code
    wr(ADDR_B_DRIVE, 16'h902a, 4'hf, RESP_OKAY);
    rd(ADDR_B_DRIVE, 16'h902a, RESP_OKAY);
    wt(3);
    chk("b_code", b_code, 32'h2a);
    chk("b_on", b_on, 1);
    hib <= 1'b1;
    wt(3);
    chk("b_on_hib_keep", b_on, 1);
    wr(ADDR_B_DRIVE, 16'h0015, 4'h1, RESP_OKAY);
    rd(ADDR_B_DRIVE, 16'h9015, RESP_OKAY);
    wr(ADDR_B_DRIVE, 16'h8015, 4'h3, RESP_OKAY);
    wt(3);
    chk("b_on_hib_off", b_on, 0);
    hib <= 1'b0;
    wt(3);
    chk("b_on_awake", b_on, 1);
    wr(ADDR_B_DRIVE, 16'h0015, 4'h3, RESP_OKAY);
    wt(3);
    chk("b_off", b_on, 0);
    // Sink A steady mode, trigger source set but ignored
    wr(ADDR_A_ENABLE, 16'h8000, 4'hf, RESP_OKAY);
    wr(ADDR_A_FLASH, 16'h6000, 4'hf, RESP_OKAY);
    wt(5);
    chk("a_on", a_on, 1);
    wt(100);
    chk("a_on_steady", a_on, 1);
    wr(ADDR_A_ENABLE, 16'h0000, 4'hf, RESP_OKAY);
    wt(3);
    chk("a_gated", a_on, 0);
    wr(ADDR_A_ENABLE, 16'h8000, 4'hf, RESP_OKAY);
    wr(ADDR_A_FLASH, 16'h0000, 4'hf, RESP_OKAY);
    wt(3);
    chk("a_off", a_on, 0);
    // Steady-mode ramps: code 01 is 256 steps of 2 cycles, code 10 twice that
    wr(ADDR_A_FLASH, 16'h2011, 4'hf, RESP_OKAY);
    wt(100);
    chk("ramp_up_mid", a_lvl != 8'h0 && a_lvl != 8'hff, 1);
    wt(600);
    chk("ramp_up_end", a_lvl, 32'hff);
    wr(ADDR_A_FLASH, 16'h0011, 4'hf, RESP_OKAY);
    wt(100);
    chk("ramp_down_mid", a_on, 1);
    wt(600);
    chk("ramp_down_end", a_on, 0);
    wr(ADDR_A_FLASH, 16'h2002, 4'hf, RESP_OKAY);
    wt(700);
    chk("ramp_slow_mid", a_lvl != 8'hff, 1);
    wt(500);
    chk("ramp_slow_end", a_lvl, 32'hff);
    wr(ADDR_A_FLASH, 16'h0000, 4'hf, RESP_OKAY);
    // Register-triggered flash at every length code
    for (int c = 0; c < 4; c++) begin
      u = (c == 3) ? 32 : c + 1;
      n0 = flashes;
      wr(ADDR_A_FLASH, 16'ha000 | 16'(c << 8), 4'hf, RESP_OKAY);
      wt(U * u + 40);
      chk("flash_count", flashes - n0, 1);
      chk("flash_len", on_len >= U * u - 1 && on_len <= U * u + 3, 1);
      rd(ADDR_A_FLASH, 16'h8000 | 16'(c << 8), RESP_OKAY);
    end
    // Flash-mode ramp code 01 steps far slower than the steady-mode one
    wr(ADDR_A_FLASH, 16'ha001, 4'hf, RESP_OKAY);
    wt(15);
    chk("flash_ramp_slow", a_lvl, 32'h0);
    wt(40);
    rd(ADDR_A_FLASH, 16'h8001, RESP_OKAY);
    // Pin trigger: drive writes have no effect
    n0 = flashes;
    wr(ADDR_A_FLASH, 16'hc000, 4'hf, RESP_OKAY);
    wr(ADDR_A_FLASH, 16'he000, 4'hf, RESP_OKAY);
    wt(60);
    chk("pin_src_drive", flashes - n0, 0);
    pin <= 1'b1;
    wt(5);
    pin <= 1'b0;
    wt(60);
    chk("pin_flash", flashes - n0, 1);
    // Periodic retrigger every 201 cycles
    wr(ADDR_A_FLASH, 16'h9000, 4'hf, RESP_OKAY);
    n0 = flashes;
    wr(ADDR_A_FLASH, 16'hb000, 4'hf, RESP_OKAY);
    wt(700);
    chk("repeat_count", flashes - n0 >= 3 && flashes - n0 <= 4, 1);
    // Power state machine clear
    psm <= 1'b1;
    wt(1);
    psm <= 1'b0;
    wt(2);
    rd(ADDR_A_ENABLE, 16'h0, RESP_OKAY);
    rd(ADDR_A_FLASH, 16'h0, RESP_OKAY);
    rd(ADDR_B_DRIVE, 16'h0, RESP_OKAY);
    wt(3);
    chk("a_cleared", a_on, 0);
    report_and_stop();
  end
endmodule // led_sink_flash_control_tb
